/* File: logic/plt_top.sv */
// pattern generator, lane checker and memory traffic engine with register port
`timescale 1ns/1ps
module plt_top
  import plt_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYC
) (
  input  logic         clock,
  input  logic         rst,
  input  plt_bus_req_t bus_req,
  output logic [31:0]  bus_rdata,
  input  logic [15:0]  pll_lock,
  input  plt_lanes_t   rx_data,
  output plt_lanes_t   tx_data,
  output plt_mem_req_t mem_req,
  input  plt_mem_rsp_t mem_rsp
);
  plt_state_t q;
  plt_state_t d;

  logic [LANES-1:0][62:0]       gnx;
  logic [LANES-1:0][62:0]       cnx;
  plt_lanes_t                   rxw;
  logic [LANES-1:0]             hit;

  // rx words come from the transceiver fabric on this same clock
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign gnx[l] = plt_step(q.pattern, q.gst[l]);
    assign cnx[l] = plt_step(q.pattern, q.cst[l]);
    assign rxw[l] = q.loopback ? q.tx[l] : rx_data[l];
    assign hit[l] = rxw[l] == cnx[l][31:0];
  end

  assign tx_data   = q.tx;
  assign mem_req   = q.req;
  assign bus_rdata = q.rdata;

  always_comb begin
    logic [LANES-1:0] mask;
    logic             wr_ctrl;
    logic             start;
    logic             stop;
    logic             clr;
    logic             ins;
    logic             link;
    logic             memr;
    logic             bad;
    logic [4:0]       nerr;
    logic             memerr;
    logic [3:0]       ins_lane;
    logic [31:0]      w;
    logic [5:0]       ph;
    logic             acc;
    logic             rtn;
    logic             mw;
    logic             rxok;
    logic [7:0]       mw_n;
    logic [7:0]       mr_n;
    logic [31:0]      wb_n;
    logic [31:0]      rb_n;
    d        = q;
    mask     = plt_mask(q.port);
    wr_ctrl  = bus_req.wr && bus_req.addr == REG_CTRL;
    start    = wr_ctrl && bus_req.wdata[CTRL_START];
    stop     = wr_ctrl && bus_req.wdata[CTRL_STOP];
    clr      = wr_ctrl && bus_req.wdata[CTRL_CLEAR];
    ins      = wr_ctrl && bus_req.wdata[CTRL_INSERT] && q.running;
    link     = q.running && !q.mem_run;
    memr     = q.running && q.mem_run;
    ins_lane = (q.port == PORT_B) ? 4'h4 : 4'h0;
    nerr     = '0;
    memerr   = 1'b0;
    ph       = '0;
    w        = '0;
    bad      = 1'b0;
    acc      = 1'b0;
    rtn      = 1'b0;
    mw       = 1'b0;
    rxok     = 1'b0;
    mw_n     = '0;
    mr_n     = '0;
    wb_n     = '0;
    rb_n     = '0;

    // pll lock passes two flops before use
    d.lock1 = pll_lock;
    d.lock2 = q.lock1;

    for (int l = 0; l < LANES; l++) begin
      // lanes outside the selected port stay quiet
      w = gnx[l][31:0];
      if (ins && link && 4'(l) == ins_lane) begin
        w[0] = ~w[0];
      end
      d.tx[l]  = (link && mask[l]) ? w : '0;
      d.gst[l] = gnx[l][62:32];
      bad      = 1'b0;
      if (link && mask[l]) begin
        bad = q.synced[l] && !hit[l];
        if (q.synced[l] || (hit[l] && q.pattern != PAT_LF)) begin
          d.cst[l] = cnx[l][62:32];
        end else if (q.pattern <= PAT_PRBS31) begin
          // self-seeding: predict the next word from the one just received
          d.cst[l] = rxw[l][30:0];
        end else if (hit[l]) begin
          d.cst[l] = cnx[l][62:32];
        end else begin
          // slip one bit per word until the square wave lines up
          ph = cnx[l][37:32];
          d.cst[l][5:0] = (ph == LF_PERIOD - 6'h01) ? 6'h00 : ph + 6'h01;
        end
        // an all-zero line would fake a prbs match, so it never syncs
        if (!q.synced[l] && hit[l] && rxw[l] != '0) begin
          d.synced[l] = 1'b1;
        end
      end else begin
        d.synced[l] = 1'b0;
      end
      d.lane_err[l] = (clr ? 32'h0000_0000 : q.lane_err[l]) + 32'(bad);
      nerr = nerr + 5'(bad);
    end

    // memory traffic engine: write the range, read it back, repeat
    acc = q.req.valid && mem_rsp.ready;
    rtn = mem_rsp.rvalid && q.mst == M_READ;
    mw  = acc && q.req.we;
    if (acc) begin
      d.req.valid = 1'b0;
    end
    if (ins && memr && !q.ins_pend) begin
      d.ins_pend = 1'b1;
    end
    if (rtn) begin
      if (mem_rsp.rdata != plt_mem_word(q.rcnt, q.iter)) begin
        memerr = 1'b1;
      end
      d.rcnt = q.rcnt + 32'h0000_0001;
    end
    unique case (q.mst)
      M_IDLE: begin
        d.req.valid = 1'b0;
      end
      M_WRITE: begin
        if (!q.req.valid || acc) begin
          if (q.waddr != q.range) begin
            d.req.valid = 1'b1;
            d.req.we    = 1'b1;
            d.req.addr  = q.waddr;
            d.req.data  = plt_mem_word(q.waddr, q.iter);
            if (q.ins_pend) begin
              d.req.data[0] = ~d.req.data[0];
              d.ins_pend    = 1'b0;
            end
            d.waddr = q.waddr + 32'h0000_0001;
          end else begin
            d.mst   = M_READ;
            d.waddr = '0;
            d.rcnt  = '0;
          end
        end
      end
      M_READ: begin
        if ((!q.req.valid || acc) && q.waddr != q.range) begin
          d.req.valid = 1'b1;
          d.req.we    = 1'b0;
          d.req.addr  = q.waddr;
          d.waddr     = q.waddr + 32'h0000_0001;
        end
        if ((!q.req.valid || acc) && q.waddr == q.range && d.rcnt == q.range) begin
          d.mst   = M_WRITE;
          d.waddr = '0;
          d.rcnt  = '0;
          d.iter  = q.iter + 32'h0000_0001;
        end
      end
    endcase

    // error counters: an error in the clearing cycle still counts
    d.det_err = (clr ? 32'h0000_0000 : q.det_err) + 32'(nerr) + 32'(memerr);
    d.ins_err = (clr ? 32'h0000_0000 : q.ins_err)
              + 32'(ins && (link || (memr && !q.ins_pend)));

    // percent of the port's full rate over a 100-cycle window
    rxok     = link && mask != '0 && (mask & ~q.synced) == '0 && nerr == '0;
    d.tx_acc = q.tx_acc + 7'(link);
    d.rx_acc = q.rx_acc + 7'(rxok);
    d.mw_acc = q.mw_acc + 7'(mw);
    d.mr_acc = q.mr_acc + 7'(rtn);
    d.win    = q.win + 7'h01;
    if (q.win == PCT_WIN - 7'h01) begin
      mw_n     = {1'b0, d.mw_acc};
      mr_n     = {1'b0, d.mr_acc};
      d.tx_pct = {1'b0, d.tx_acc};
      d.rx_pct = {1'b0, d.rx_acc};
      d.mw_pct = mw_n;
      d.mr_pct = mr_n;
      d.mt_pct = 8'((9'(mw_n) + 9'(mr_n)) >> 1);
      d.win    = '0;
      d.tx_acc = '0;
      d.rx_acc = '0;
      d.mw_acc = '0;
      d.mr_acc = '0;
    end

    // bytes moved in each one-second window
    wb_n      = q.wb_acc + (mw ? MEM_WORD_BYTES : 32'h0000_0000);
    rb_n      = q.rb_acc + (rtn ? MEM_WORD_BYTES : 32'h0000_0000);
    d.wb_acc  = wb_n;
    d.rb_acc  = rb_n;
    d.sec_cnt = q.sec_cnt + 32'h0000_0001;
    if (q.sec_cnt == 32'(SEC_CYCLES - 1)) begin
      d.wbps    = wb_n;
      d.rbps    = rb_n;
      d.tbps    = wb_n + rb_n;
      d.sec_cnt = '0;
      d.wb_acc  = '0;
      d.rb_acc  = '0;
    end

    // control writes
    if (bus_req.wr) begin
      if (bus_req.addr == REG_CONFIG) begin
        d.pattern  = bus_req.wdata[CFG_PAT +: 3];
        d.port     = bus_req.wdata[CFG_PORT +: 2];
        d.loopback = bus_req.wdata[CFG_LOOP];
        d.mem_cfg  = bus_req.wdata[CFG_MEM];
      end
      if (bus_req.addr == REG_RANGE) begin
        d.range = bus_req.wdata;
      end
    end
    if (start) begin
      // a start does not clear the error counters; software clears first
      d.running  = 1'b1;
      d.mem_run  = q.mem_cfg;
      d.synced   = '0;
      d.ins_pend = 1'b0;
      d.mst      = q.mem_cfg ? M_WRITE : M_IDLE;
      d.req      = '0;
      d.waddr    = '0;
      d.rcnt     = '0;
      d.iter     = '0;
      d.sec_cnt  = '0;
      d.wb_acc   = '0;
      d.rb_acc   = '0;
      d.wbps     = '0;
      d.rbps     = '0;
      d.tbps     = '0;
      for (int l = 0; l < LANES; l++) begin
        d.gst[l] = GEN_SEED;
      end
    end else if (stop) begin
      d.running = 1'b0;
      d.mst     = M_IDLE;
      d.req     = '0;
      d.synced  = '0;
    end

    // read data stand only in the cycle after the strobe
    d.rdata = '0;
    if (bus_req.rd) begin
      if (bus_req.addr[7:6] == REG_LANE_BLK) begin
        d.rdata = q.lane_err[bus_req.addr[5:2]];
      end else begin
        case (bus_req.addr)
          REG_CONFIG:   d.rdata = {19'h0_0000, q.mem_cfg, 3'h0, q.loopback,
                                   2'h0, q.port, 1'b0, q.pattern};
          REG_STATUS:   d.rdata = {28'h000_0000, q.ins_pend, q.mst, q.running};
          REG_LOCK:     d.rdata = {16'h0000, q.lock2};
          REG_SYNC:     d.rdata = {16'h0000, q.synced};
          REG_DET_ERR:  d.rdata = q.det_err;
          REG_INS_ERR:  d.rdata = q.ins_err;
          REG_RANGE:    d.rdata = q.range;
          REG_LINK_PCT: d.rdata = {16'h0000, q.rx_pct, q.tx_pct};
          REG_MEM_PCT:  d.rdata = {8'h00, q.mt_pct, q.mr_pct, q.mw_pct};
          REG_WR_BPS:   d.rdata = q.wbps;
          REG_RD_BPS:   d.rdata = q.rbps;
          REG_TOT_BPS:  d.rdata = q.tbps;
          default:      d.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q       <= '0;
      q.range <= RANGE_RST;
    end else begin
      q <= d;
    end
  end
endmodule

/* File: logic/plt_pkg.sv */
// constants, carriers and pattern functions of the loopback and memory tester
// Operation
// - prbs7 and prbs15 selections drive generator and checker with that sequence
// - prbs23 and prbs31 selections drive generator and checker with that sequence
// - high frequency pattern alternates every bit, half the line rate
// - low frequency pattern is a square wave of period thirty-three bits
// - each lane flags sync once the expected sequence start is seen
// - each lane reports its transceiver pll locked or unlocked
// - detected errors are counted in hardware and readable by software
// - injected errors are counted in a separate counter
// - each link-mode insert corrupts exactly one transmitted word and counts once
// - insert requests are ignored unless a run is active
// - clear zeroes both detected and inserted error counters
// - start begins generation and checking, stop ends the run
// - serial loopback feeds each lane's transmit word to its own receiver
// - one of two four-lane ports or all sixteen lanes is chosen; only those lanes are exercised
// - transmit and receive throughput are reported as percent of maximum
// - memory traffic uses a 72-bit bus with 8 ecc bits, ddr 1066
// - memory write, read, total bytes per second measured over each one-second window
// - memory insert corrupts one written word so readback detects it
// - write, read and combined byte rates are reported separately
// - an address range sets the addresses of each write-then-read pass
package plt_pkg;
  localparam int LANES       = 16;
  localparam int WORD_W      = 32;
  localparam int MEM_W       = 72;
  localparam int MEM_ECC_W   = 8;
  localparam int MEM_CLK_MHZ = 1066;
  localparam int MEM_DDR     = 2;
  localparam int CLK_HZ      = 20_000_000;
  localparam int MEAS_S      = 1;
  localparam int SEC_CYC     = CLK_HZ * MEAS_S;

  localparam logic [31:0] MEM_WORD_BYTES = 32'h0000_0008;
  localparam logic [6:0]  PCT_WIN        = 7'h64;
  localparam logic [5:0]  LF_PERIOD      = 6'h21;
  localparam logic [5:0]  LF_HIGH        = 6'h10;
  localparam logic [30:0] GEN_SEED       = 31'h7FFF_FFC0;
  localparam logic [31:0] RANGE_RST      = 32'h0000_0100;

  localparam logic [2:0] PAT_PRBS7  = 3'h0;
  localparam logic [2:0] PAT_PRBS15 = 3'h1;
  localparam logic [2:0] PAT_PRBS23 = 3'h2;
  localparam logic [2:0] PAT_PRBS31 = 3'h3;
  localparam logic [2:0] PAT_HF     = 3'h4;
  localparam logic [2:0] PAT_LF     = 3'h5;

  localparam logic [1:0] PORT_A   = 2'h0;
  localparam logic [1:0] PORT_B   = 2'h1;
  localparam logic [1:0] PORT_X16 = 2'h2;

  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CONFIG   = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_LOCK     = 8'h0C;
  localparam logic [7:0] REG_SYNC     = 8'h10;
  localparam logic [7:0] REG_DET_ERR  = 8'h14;
  localparam logic [7:0] REG_INS_ERR  = 8'h18;
  localparam logic [7:0] REG_RANGE    = 8'h1C;
  localparam logic [7:0] REG_LINK_PCT = 8'h20;
  localparam logic [7:0] REG_MEM_PCT  = 8'h24;
  localparam logic [7:0] REG_WR_BPS   = 8'h28;
  localparam logic [7:0] REG_RD_BPS   = 8'h2C;
  localparam logic [7:0] REG_TOT_BPS  = 8'h30;
  localparam logic [1:0] REG_LANE_BLK = 2'h1;

  localparam int CTRL_START  = 0;
  localparam int CTRL_STOP   = 1;
  localparam int CTRL_CLEAR  = 2;
  localparam int CTRL_INSERT = 3;
  localparam int CFG_PAT     = 0;
  localparam int CFG_PORT    = 4;
  localparam int CFG_LOOP    = 8;
  localparam int CFG_MEM     = 12;

  typedef logic [LANES-1:0][WORD_W-1:0] plt_lanes_t;
  typedef enum logic [1:0] {M_IDLE, M_WRITE, M_READ} plt_mem_st_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } plt_bus_req_t;

  typedef struct packed {
    logic             valid;
    logic             we;
    logic [31:0]      addr;
    logic [MEM_W-1:0] data;
  } plt_mem_req_t;

  typedef struct packed {
    logic             ready;
    logic             rvalid;
    logic [MEM_W-1:0] rdata;
  } plt_mem_rsp_t;

  typedef struct packed {
    logic                         running;
    logic                         mem_run;
    logic                         mem_cfg;
    logic                         loopback;
    logic [2:0]                   pattern;
    logic [1:0]                   port;
    logic [31:0]                  range;
    logic [LANES-1:0]             lock1;
    logic [LANES-1:0]             lock2;
    logic [LANES-1:0]             synced;
    logic [LANES-1:0][30:0]       gst;
    logic [LANES-1:0][30:0]       cst;
    plt_lanes_t                   tx;
    plt_lanes_t                   lane_err;
    logic [31:0]                  det_err;
    logic [31:0]                  ins_err;
    plt_mem_st_t                  mst;
    logic [31:0]                  iter;
    logic [31:0]                  waddr;
    logic [31:0]                  rcnt;
    logic                         ins_pend;
    plt_mem_req_t                 req;
    logic [6:0]                   win;
    logic [6:0]                   tx_acc;
    logic [6:0]                   rx_acc;
    logic [6:0]                   mw_acc;
    logic [6:0]                   mr_acc;
    logic [7:0]                   tx_pct;
    logic [7:0]                   rx_pct;
    logic [7:0]                   mw_pct;
    logic [7:0]                   mr_pct;
    logic [7:0]                   mt_pct;
    logic [31:0]                  sec_cnt;
    logic [31:0]                  wb_acc;
    logic [31:0]                  rb_acc;
    logic [31:0]                  wbps;
    logic [31:0]                  rbps;
    logic [31:0]                  tbps;
    logic [31:0]                  rdata;
  } plt_state_t;

  // one word of pattern: {next state, word}, newest bit in bit 0
  function automatic logic [62:0] plt_step(input logic [2:0] m, input logic [30:0] s);
    logic [30:0] st;
    logic [31:0] w;
    logic        b;
    st = s;
    w  = '0;
    b  = 1'b0;
    for (int i = 0; i < WORD_W; i++) begin
      case (m)
        PAT_PRBS7:  b = st[6] ^ st[5];
        PAT_PRBS15: b = st[14] ^ st[13];
        PAT_PRBS23: b = st[22] ^ st[17];
        PAT_PRBS31: b = st[30] ^ st[27];
        PAT_HF:     b = ~w[0];
        PAT_LF:     b = st[5:0] < LF_HIGH;
        default:    b = 1'b0;
      endcase
      w = {w[30:0], b};
      if (m == PAT_LF) begin
        st[5:0] = (st[5:0] == LF_PERIOD - 6'h01) ? 6'h00 : st[5:0] + 6'h01;
      end else begin
        st = {st[29:0], b};
      end
    end
    return {st, w};
  endfunction

  function automatic logic [LANES-1:0] plt_mask(input logic [1:0] p);
    case (p)
      PORT_A:   return 16'h000F;
      PORT_B:   return 16'h00F0;
      PORT_X16: return 16'hFFFF;
      default:  return 16'h0000;
    endcase
  endfunction

  // memory word from address and pass number, ecc byte is xor of data bytes
  function automatic logic [MEM_W-1:0] plt_mem_word(input logic [31:0] a, input logic [31:0] it);
    logic [63:0]          dw;
    logic [MEM_ECC_W-1:0] e;
    dw = {a ^ it, ~a};
    e  = '0;
    for (int i = 0; i < 8; i++) begin
      e = e ^ dw[i*8 +: 8];
    end
    return {e, dw};
  endfunction
endpackage

/* File: verif/plt_top_sva.sv */
// assertions on register port, lanes and memory requests of the tester
`timescale 1ns/1ps
module plt_top_sva
  import plt_pkg::*;
(
  input logic         clock,
  input logic         rst,
  input plt_bus_req_t bus_req,
  input logic [31:0]  bus_rdata,
  input logic [15:0]  pll_lock,
  input plt_lanes_t   rx_data,
  input plt_lanes_t   tx_data,
  input plt_mem_req_t mem_req,
  input plt_mem_rsp_t mem_rsp
);
  logic [31:0]      cfg;
  logic [LANES-1:0] msk;
  plt_lanes_t       off;
  logic             ctl_wr;
  logic             ins_prev;
  // config shadow; valid because config only changes while stopped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg      <= 32'h0000_0000;
      ins_prev <= 1'b0;
    end else begin
      ins_prev <= ctl_wr && bus_req.wdata[CTRL_INSERT];
      if (bus_req.wr && bus_req.addr == REG_CONFIG) begin
        cfg <= bus_req.wdata;
      end
    end
  end
  assign msk    = plt_mask(cfg[CFG_PORT +: 2]);
  assign ctl_wr = bus_req.wr && bus_req.addr == REG_CTRL;
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      off[i] = msk[i] ? 32'h0000_0000 : 32'hFFFF_FFFF;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  a_ctrl_reads_zero: assert property (bus_req.rd && bus_req.addr == REG_CTRL
    |=> bus_rdata == 32'h0000_0000) else $error("control register read not zero");
  a_unmapped_zero: assert property (bus_req.rd && (bus_req.addr inside {[8'h34:8'h3C],
    [8'h80:8'hFF]}) |=> bus_rdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_lock_delay: assert property (bus_req.rd && bus_req.addr == REG_LOCK
    |=> bus_rdata[15:0] == $past(pll_lock, 3)) else $error("lock status wrong");
  a_clear_ins: assert property (ctl_wr && bus_req.wdata[CTRL_CLEAR]
    && !bus_req.wdata[CTRL_INSERT] ##[1:2] bus_req.rd && bus_req.addr == REG_INS_ERR
    && !ins_prev |=> bus_rdata == 32'h0000_0000) else $error("inserted count not cleared");
  a_mem_hold: assert property (mem_req.valid && !mem_rsp.ready && !bus_req.wr
    |=> $stable(mem_req)) else $error("memory request changed before accept");
  a_stop_tx_zero: assert property (ctl_wr && bus_req.wdata[CTRL_STOP]
    && !bus_req.wdata[CTRL_START] |=> ##1 tx_data == '0) else $error("tx not idle after stop");
  a_lane_unused: assert property ((tx_data & off) == '0)
    else $error("unselected lane driven");
  a_hf_word: assert property (cfg[2:0] == PAT_HF && tx_data[0] != 32'h0000_0000
    |-> tx_data[0][31:1] == 31'h5555_5555) else $error("high frequency word wrong");

  c_insert: cover property (ctl_wr && bus_req.wdata[CTRL_INSERT]);
  c_mem_wr: cover property (mem_req.valid && mem_req.we && mem_rsp.ready);
  c_mem_stall: cover property (mem_req.valid && !mem_rsp.ready);
  c_mem_rd: cover property (mem_rsp.rvalid);
endmodule

bind plt_top plt_top_sva plt_top_sva_i (.clock(clock), .rst(rst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .pll_lock(pll_lock), .rx_data(rx_data), .tx_data(tx_data),
  .mem_req(mem_req), .mem_rsp(mem_rsp));

/* File: verif/plt_far_end.sv */
// far end: external lane loopback and a small in-order memory
`timescale 1ns/1ps
module plt_far_end
  import plt_pkg::*;
(
  input  logic         clock,
  input  logic         rst,
  input  logic         slow,
  input  plt_lanes_t   tx_data,
  input  plt_mem_req_t mem_req,
  output plt_lanes_t   rx_data,
  output plt_mem_rsp_t mem_rsp
);
  logic [MEM_W-1:0] mem [0:255];
  logic [7:0]       rq [$];
  logic             tog;
  logic             ready;
  logic             rvalid;
  logic [MEM_W-1:0] rdata;
  // slow mode accepts and returns only every other cycle
  assign ready   = slow ? tog : 1'b1;
  assign mem_rsp = '{ready, rvalid, rdata};
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tog     <= 1'b0;
      rx_data <= '0;
      rvalid  <= 1'b0;
      rdata   <= '0;
    end else begin
      tog     <= ~tog;
      rx_data <= tx_data;
      if (mem_req.valid && ready && mem_req.we) begin
        mem[mem_req.addr[7:0]] <= mem_req.data;
      end
      if (rq.size() > 0 && (!slow || tog)) begin
        rvalid <= 1'b1;
        rdata  <= mem[rq.pop_front()];
      end else begin
        rvalid <= 1'b0;
        // released bus: inverted each idle cycle, so the last word reappears every other cycle
        rdata  <= ~rdata;
      end
      if (mem_req.valid && ready && !mem_req.we) begin
        rq.push_back(mem_req.addr[7:0]);
      end
    end
  end
endmodule

/* File: verif/testbench.sv */
// register-level tests of the tester against the far-end model
`timescale 1ns/1ps
module testbench
  import plt_pkg::*;
;
  logic         clock;
  logic         rst;
  logic         slow;
  plt_bus_req_t bus_req;
  logic [31:0]  bus_rdata;
  logic [15:0]  pll_lock;
  plt_lanes_t   rx_data;
  plt_lanes_t   tx_data;
  plt_mem_req_t mem_req;
  plt_mem_rsp_t mem_rsp;
  int           failures;
  int           n_compared;
  logic [31:0]  rv;
  logic [31:0]  wb;
  logic [31:0]  rb;
  logic [95:0]  prev;

  plt_top #(.SEC_CYCLES(200)) plt_top_i (.clock(clock), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .pll_lock(pll_lock), .rx_data(rx_data), .tx_data(tx_data),
    .mem_req(mem_req), .mem_rsp(mem_rsp));
  plt_far_end plt_far_end_i (.clock(clock), .rst(rst), .slow(slow), .tx_data(tx_data),
    .mem_req(mem_req), .rx_data(rx_data), .mem_rsp(mem_rsp));

  always #25 clock = ~clock;

  function automatic logic [31:0] cfgw(input logic [2:0] p, input logic [1:0] pt,
                                        input logic lb, input logic m);
    return {19'h0_0000, m, 3'h0, lb, 2'h0, pt, 1'h0, p};
  endfunction

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    rd(a, d);
    chk(nm, exp, d);
  endtask

  // two words of lane 0 checked against the pattern law, bit 0 newest
  task automatic pat_chk(input logic [2:0] p);
    logic [63:0] s;
    int          bad;
    int          ones;
    int          ta;
    int          tb;
    bad  = 0;
    ones = 0;
    @(posedge clock);
    #1;
    s[63:32] = tx_data[0];
    @(posedge clock);
    #1;
    s[31:0] = tx_data[0];
    case (p)
      PAT_PRBS7:  begin ta = 7;  tb = 6;  end
      PAT_PRBS15: begin ta = 15; tb = 14; end
      PAT_PRBS23: begin ta = 23; tb = 18; end
      default:    begin ta = 31; tb = 28; end
    endcase
    for (int k = 0; k < 31; k++) begin
      if (p == PAT_LF) begin
        bad += (s[k] != s[k+33]);
      end else begin
        bad += (s[k] != (s[k+ta] ^ s[k+tb]));
      end
    end
    for (int k = 0; k < 33; k++) begin
      ones += s[k];
    end
    if (p == PAT_HF) begin
      chk("hf word", 32'hAAAA_AAAA, s[31:0]);
    end else if (p == PAT_LF) begin
      chk("lf period", 32'h0000_0000, 32'(bad));
      chk("lf ones", 32'h0000_0010, 32'(ones));
    end else begin
      chk("prbs law", 32'h0000_0000, 32'(bad));
      chk("prbs live", 32'h0000_0001, 32'(s != 64'h0));
    end
  endtask

  initial begin
    clock    = 1'b0;
    rst      = 1'b1;
    slow     = 1'b0;
    bus_req  = '0;
    pll_lock = 16'h0000;
    failures   = 0;
    n_compared = 0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rc(REG_RANGE, RANGE_RST, "range reset");
    rc(REG_STATUS, 32'h0000_0000, "status reset");
    rc(REG_CTRL, 32'h0000_0000, "ctrl reads zero");
    rc(8'h34, 32'h0000_0000, "unmapped");
    rc(8'h80, 32'h0000_0000, "unmapped high");
    $display("test reset done");
    for (int p = 0; p < 6; p++) begin
      wr(REG_CONFIG, cfgw(p[2:0], (p == 3) ? PORT_X16 : PORT_A, 1'b1, 1'b0));
      wr(REG_CTRL, 32'h0000_0004);
      wr(REG_CTRL, 32'h0000_0001);
      // long enough for one whole percent window after sync
      repeat (250) @(posedge clock);
      pat_chk(p[2:0]);
      rc(REG_SYNC, (p == 3) ? 32'h0000_FFFF : 32'h0000_000F, "sync port");
      rc(REG_DET_ERR, 32'h0000_0000, "clean run");
      rc(REG_LINK_PCT, 32'h0000_6464, "link percent");
      wr(REG_CTRL, 32'h0000_0002);
      $display("test pattern %0d done", p);
    end
    wr(REG_CONFIG, cfgw(PAT_PRBS15, PORT_B, 1'b0, 1'b0));
    wr(REG_CTRL, 32'h0000_0004);
    wr(REG_CTRL, 32'h0000_0001);
    repeat (40) @(posedge clock);
    rc(REG_STATUS, 32'h0000_0001, "running");
    rc(REG_SYNC, 32'h0000_00F0, "sync port b");
    rc(REG_INS_ERR, 32'h0000_0000, "no inserts");
    wr(REG_CTRL, 32'h0000_0008);
    repeat (6) @(posedge clock);
    rc(REG_INS_ERR, 32'h0000_0001, "one insert");
    rc(REG_DET_ERR, 32'h0000_0001, "one detect");
    rc(8'h50, 32'h0000_0001, "lane 4 count");
    wr(REG_CTRL, 32'h0000_0008);
    wr(REG_CTRL, 32'h0000_0008);
    repeat (6) @(posedge clock);
    rc(REG_INS_ERR, 32'h0000_0003, "three inserts");
    rc(REG_DET_ERR, 32'h0000_0003, "three detects");
    wr(REG_CTRL, 32'h0000_0002);
    rc(REG_STATUS, 32'h0000_0000, "stopped");
    wr(REG_CTRL, 32'h0000_0008);
    repeat (6) @(posedge clock);
    rc(REG_INS_ERR, 32'h0000_0003, "idle insert");
    wr(REG_CTRL, 32'h0000_0004);
    rc(REG_INS_ERR, 32'h0000_0000, "ins cleared");
    rc(REG_DET_ERR, 32'h0000_0000, "det cleared");
    pll_lock <= 16'hA5C3;
    repeat (4) @(posedge clock);
    rc(REG_LOCK, 32'h0000_A5C3, "pll lock");
    $display("test errors and lock done");
    slow <= 1'b1;
    wr(REG_RANGE, 32'h0000_0008);
    wr(REG_CONFIG, cfgw(PAT_PRBS7, PORT_A, 1'b0, 1'b1));
    wr(REG_CTRL, 32'h0000_0004);
    wr(REG_CTRL, 32'h0000_0001);
    repeat (450) @(posedge clock);
    wr(REG_CTRL, 32'h0000_0008);
    rv = 32'h0000_0000;
    for (int i = 0; i < 60 && rv == 32'h0000_0000; i++) begin
      rd(REG_DET_ERR, rv);
    end
    chk("mem detect", 32'h0000_0001, rv);
    rc(REG_INS_ERR, 32'h0000_0001, "mem insert");
    // a window edge may split one set of reads; a repeated set is then clean
    prev = '1;
    for (int t = 0; t < 3; t++) begin
      rd(REG_WR_BPS, wb);
      rd(REG_RD_BPS, rb);
      rd(REG_TOT_BPS, rv);
      if ({wb, rb, rv} == prev) begin
        break;
      end
      prev = {wb, rb, rv};
    end
    chk("total bytes", wb + rb, rv);
    chk("write bytes live", 32'h0000_0001, 32'(wb != 32'h0));
    chk("word bytes", 32'h0000_0000, 32'(wb[2:0] | rb[2:0]));
    rd(REG_MEM_PCT, rv);
    chk("mem total pct", 32'((rv[7:0] + rv[15:8]) / 2), 32'(rv[23:16]));
    wr(REG_CTRL, 32'h0000_0002);
    $display("test memory done");
    complete_run();
  end
endmodule
